// File: acc_pkg.sv
// Shared constants for the converter channel control block
package acc_pkg;
	// Register byte offsets on the APB slave
	localparam logic [11:0] ACC_OFF_CONTROL = 12'h000;
	localparam logic [11:0] ACC_OFF_RESULT_HIGH = 12'h004;
	localparam logic [11:0] ACC_OFF_RESULT_LOW = 12'h008;
	localparam logic [11:0] ACC_OFF_STATUS = 12'h00c;

	// Control register field positions
	localparam int ACC_CTL_CHAN_LSB = 4;
	localparam int ACC_CTL_CHAN_W = 4;
	localparam int ACC_CTL_DIFF_BIT = 3;
	localparam int ACC_CTL_MUXOUT_BIT = 2;
	localparam int ACC_CTL_DIV16_BIT = 1;
	localparam int ACC_CTL_ACTIVE_BIT = 0;
	localparam logic [7:0] ACC_CTL_RESET = 8'h00;

	// Result layout
	localparam int ACC_RES_W = 10;
	localparam int ACC_RES_LOW_LSB = 6;

	// Status register field positions
	localparam int ACC_STA_ACTIVE_BIT = 0;
	localparam int ACC_STA_UNUSABLE_BIT = 1;
	localparam int ACC_STA_ROUTED_BIT = 2;

	// Converter clock counts per phase
	localparam int ACC_SAMPLE_CLKS = 3;
	localparam int ACC_AZERO_CLKS = 1;
	localparam int ACC_APPROX_CLKS = 10;
	localparam int ACC_LOAD_CLKS = 1;
	localparam int ACC_CONV_CLKS = ACC_SAMPLE_CLKS + ACC_AZERO_CLKS
		+ ACC_APPROX_CLKS + ACC_LOAD_CLKS;

	// Prescale ratios
	localparam int ACC_DIV_SLOW = 16;
	localparam int ACC_DIV_FAST = 1;

	// Channel codes that change meaning when the mux path is routed out
	localparam logic [3:0] ACC_CH_DIFF_UNUSED = 4'hc;
	localparam logic [3:0] ACC_CH_DIFF_NEGOUT = 4'hd;
	localparam logic [3:0] ACC_CH_MUX_OUT = 4'he;
	localparam logic [3:0] ACC_CH_CONV_IN = 4'hf;

	typedef enum logic [2:0] {
		ACC_IDLE,
		ACC_SAMPLE,
		ACC_AZERO,
		ACC_APPROX,
		ACC_LOAD
	} acc_phase_t;
endpackage

// File: acc_conv_clock.sv
// Converter clock prescaler producing one-cycle converter clock ticks
`timescale 1ns/10ps
module acc_conv_clock #(
	parameter int DIV_SLOW = acc_pkg::ACC_DIV_SLOW
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Control
	input wire logic enable,
	input wire logic divSlow,
	// Tick out
	output logic convTick
);
	import acc_pkg::*;

	localparam int CW = $clog2(DIV_SLOW);
	localparam logic [CW-1:0] LIM_SLOW = CW'(DIV_SLOW - 1);
	localparam logic [CW-1:0] LIM_FAST = CW'(ACC_DIV_FAST - 1);

	logic [CW-1:0] divCount;
	logic [CW-1:0] limit;

	assign limit = divSlow ? LIM_SLOW : LIM_FAST;

	// Held at zero while idle so the converter clock is off
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			divCount <= '0;
		end else if (!enable || divCount >= limit) begin
			divCount <= '0;
		end else begin
			divCount <= divCount + CW'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			convTick <= 1'b0;
		end else begin
			convTick <= enable && divCount >= limit;
		end
	end
endmodule // acc_conv_clock

// File: acc_adc_channel_control.sv
// Control logic of a 16-channel 10-bit successive-approximation converter
// What this block does
// - Reset clears the control register and powers the converter down.
// - Control byte: channel 7:4, diff 3, mux path 2, prescale 1, active 0.
// - Writing one to the active bit starts a conversion with current settings.
// - Hardware clears the active bit as the result lands in result registers.
// - Single-ended: one conversion of the selected channel, then stop.
// - Differential: one conversion of the selected pair, then stop.
// - Four-bit field picks one of sixteen channels as positive input.
// - Negative is ground single-ended; pair partner n xor 1 in differential.
// - Mux path off: all sixteen codes are valid in both modes.
// - Mux path on: codes 14, 15 and differential 12, 13 change use.
// - Mux path on routes mux output and converter input to pins.
// - While active, control writes change only the active bit.
// - A conversion is 3 sample, 1 auto-zero, 10 approximation, 1 load clocks.
// - Prescale bit: zero divides by one, one divides by sixteen.
// - High result holds bits 9:2; low holds bits 1:0 at 7:6, rest zero.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module acc_adc_channel_control #(
	parameter int ADDR_W = 12,
	parameter int CHANNELS = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter core
	output logic convPower,
	output logic convTick,
	output logic sampleOn,
	output logic autoZeroOn,
	output logic [acc_pkg::ACC_RES_W-1:0] trialCode,
	input wire logic compHigh,
	// Analog multiplexer
	output logic [CHANNELS-1:0] posSelect,
	output logic [CHANNELS-1:0] negSelect,
	output logic negToGround,
	output logic muxPinRoute
);
	import acc_pkg::*;

	localparam int CH_W = ACC_CTL_CHAN_W;

	// Control register fields
	logic [CH_W-1:0] chanSel;
	logic diffMode;
	logic muxOut;
	logic divSlow;
	logic active;

	// Results
	logic [7:0] resultHigh;
	logic [1:0] resultLow;

	// Sequencer
	acc_phase_t phase;
	acc_phase_t next_phase;
	logic [3:0] phaseCount;
	logic [3:0] next_phaseCount;
	logic [ACC_RES_W-1:0] sarCode;
	logic [ACC_RES_W-1:0] sarBit;
	logic tickRaw;
	logic lastTick;

	// Bus decode
	logic setupCyc;
	logic wrTake;
	logic wrLane0;
	logic [ADDR_W-1:0] regAddr;
	logic addrHit;
	logic [31:0] readMux;
	logic ctlWrite;
	logic startReq;
	logic stopReq;
	logic convDone;
	logic selUnusable;
	logic [CH_W-1:0] negCode;

	assign regAddr = paddr;
	assign setupCyc = psel && !penable;
	assign wrTake = psel && penable && pready && pwrite && !pslverr;
	assign wrLane0 = pstrb[0];
	assign ctlWrite = wrTake && wrLane0 && regAddr == ADDR_W'(ACC_OFF_CONTROL);

	// Start only from idle; restart needs a stop write first
	assign startReq = ctlWrite && !active && pwdata[ACC_CTL_ACTIVE_BIT];
	assign stopReq = ctlWrite && active && !pwdata[ACC_CTL_ACTIVE_BIT];
	assign convDone = phase == ACC_LOAD && tickRaw;

	always_comb begin
		addrHit = 1'b1;
		readMux = 32'h0000_0000;
		case (regAddr)
			ADDR_W'(ACC_OFF_CONTROL): begin
				readMux[7:0] = {chanSel, diffMode, muxOut, divSlow, active};
			end
			ADDR_W'(ACC_OFF_RESULT_HIGH): begin
				readMux[7:0] = resultHigh;
			end
			ADDR_W'(ACC_OFF_RESULT_LOW): begin
				readMux[7:ACC_RES_LOW_LSB] = resultLow;
			end
			ADDR_W'(ACC_OFF_STATUS): begin
				readMux[ACC_STA_ACTIVE_BIT] = active;
				readMux[ACC_STA_UNUSABLE_BIT] = selUnusable;
				readMux[ACC_STA_ROUTED_BIT] = muxOut;
			end
			default: begin
				addrHit = 1'b0;
			end
		endcase
	end

	// One wait-free access phase; read data captured in the setup cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setupCyc;
			pslverr <= setupCyc && !addrHit;
			if (setupCyc) begin
				prdata <= (!pwrite && addrHit) ? readMux : 32'h0000_0000;
			end
		end
	end

	// Settings fields, frozen while a conversion runs
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			chanSel <= ACC_CTL_RESET[7:ACC_CTL_CHAN_LSB];
			diffMode <= ACC_CTL_RESET[ACC_CTL_DIFF_BIT];
			muxOut <= ACC_CTL_RESET[ACC_CTL_MUXOUT_BIT];
			divSlow <= ACC_CTL_RESET[ACC_CTL_DIV16_BIT];
		end else if (ctlWrite && !active) begin
			chanSel <= pwdata[ACC_CTL_CHAN_LSB +: CH_W];
			diffMode <= pwdata[ACC_CTL_DIFF_BIT];
			muxOut <= pwdata[ACC_CTL_MUXOUT_BIT];
			divSlow <= pwdata[ACC_CTL_DIV16_BIT];
		end
	end

	// Active bit: set by software, cleared by completion or a stop write
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			active <= ACC_CTL_RESET[ACC_CTL_ACTIVE_BIT];
		end else if (convDone || stopReq) begin
			active <= 1'b0;
		end else if (startReq) begin
			active <= 1'b1;
		end
	end

	// Converter clock stops whenever the block is idle
	acc_conv_clock #(
		.DIV_SLOW(ACC_DIV_SLOW)
	) u_conv_clock (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.enable(active),
		.divSlow(divSlow),
		.convTick(tickRaw)
	);

	assign lastTick = tickRaw && phaseCount == 4'h0;

	always_comb begin
		next_phase = phase;
		next_phaseCount = phaseCount;
		case (phase)
			ACC_IDLE: begin
				if (startReq) begin
					next_phase = ACC_SAMPLE;
					next_phaseCount = 4'(ACC_SAMPLE_CLKS - 1);
				end
			end
			ACC_SAMPLE: begin
				if (lastTick) begin
					next_phase = ACC_AZERO;
					next_phaseCount = 4'(ACC_AZERO_CLKS - 1);
				end else if (tickRaw) begin
					next_phaseCount = phaseCount - 4'h1;
				end
			end
			ACC_AZERO: begin
				if (lastTick) begin
					next_phase = ACC_APPROX;
					next_phaseCount = 4'(ACC_APPROX_CLKS - 1);
				end else if (tickRaw) begin
					next_phaseCount = phaseCount - 4'h1;
				end
			end
			ACC_APPROX: begin
				if (lastTick) begin
					next_phase = ACC_LOAD;
					next_phaseCount = 4'(ACC_LOAD_CLKS - 1);
				end else if (tickRaw) begin
					next_phaseCount = phaseCount - 4'h1;
				end
			end
			ACC_LOAD: begin
				// Single shot in either mode: no rescan, no auto restart
				if (tickRaw) begin
					next_phase = ACC_IDLE;
					next_phaseCount = 4'h0;
				end
			end
			default: begin
				next_phase = ACC_IDLE;
				next_phaseCount = 4'h0;
			end
		endcase
		if (stopReq) begin
			next_phase = ACC_IDLE;
			next_phaseCount = 4'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= ACC_IDLE;
			phaseCount <= 4'h0;
		end else begin
			phase <= next_phase;
			phaseCount <= next_phaseCount;
		end
	end

	// Trial output is the approximation register: no lag at one tick a cycle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			trialCode <= '0;
			sarBit <= '0;
		end else if (phase == ACC_AZERO && lastTick) begin
			trialCode <= ACC_RES_W'(1) << (ACC_RES_W - 1);
			sarBit <= ACC_RES_W'(1) << (ACC_RES_W - 1);
		end else if (phase == ACC_APPROX && tickRaw) begin
			trialCode <= (compHigh ? trialCode : (trialCode & ~sarBit)) | (sarBit >> 1);
			sarBit <= sarBit >> 1;
		end
	end
	assign sarCode = trialCode;

	// Results load on the completion edge that clears the active bit
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			resultHigh <= 8'h00;
			resultLow <= 2'h0;
		end else if (convDone) begin
			resultHigh <= sarCode[ACC_RES_W-1:2];
			resultLow <= sarCode[1:0];
		end else if (wrTake && wrLane0) begin
			if (regAddr == ADDR_W'(ACC_OFF_RESULT_HIGH)) begin
				resultHigh <= pwdata[7:0];
			end
			if (regAddr == ADDR_W'(ACC_OFF_RESULT_LOW)) begin
				resultLow <= pwdata[7:ACC_RES_LOW_LSB];
			end
		end
	end

	// Negative partner: even code pairs upward, odd code downward
	assign negCode = {chanSel[CH_W-1:1], ~chanSel[0]};

	// Codes that the routed mux path takes over; software must avoid them
	always_comb begin
		selUnusable = 1'b0;
		if (muxOut) begin
			if (chanSel == ACC_CH_MUX_OUT || chanSel == ACC_CH_CONV_IN) begin
				selUnusable = 1'b1;
			end
			if (diffMode && (chanSel == ACC_CH_DIFF_UNUSED
				|| chanSel == ACC_CH_DIFF_NEGOUT)) begin
				selUnusable = 1'b1;
			end
		end
	end

	// Multiplexer gates; with the pin route on they stay enabled while idle
	// so the external filter can settle before the start write
	generate
		for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					posSelect[ch] <= 1'b0;
					negSelect[ch] <= 1'b0;
				end else begin
					posSelect[ch] <= (active || muxOut) && !selUnusable
						&& chanSel == CH_W'(ch);
					negSelect[ch] <= (active || muxOut) && !selUnusable
						&& diffMode && negCode == CH_W'(ch);
				end
			end
		end
	endgenerate

	// Power, tick and phase outputs follow the phase register, so power spans the final load tick; ground and pin route follow the settings
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			convPower <= 1'b0;
			convTick <= 1'b0;
			sampleOn <= 1'b0;
			autoZeroOn <= 1'b0;
			negToGround <= 1'b0;
			muxPinRoute <= 1'b0;
		end else begin
			convPower <= phase != ACC_IDLE;
			convTick <= tickRaw && phase != ACC_IDLE;
			sampleOn <= phase == ACC_SAMPLE;
			autoZeroOn <= phase == ACC_AZERO;
			negToGround <= !diffMode;
			muxPinRoute <= muxOut;
		end
	end
endmodule // acc_adc_channel_control

// File: acc_core_model.sv
// Behavioural analog mux and comparator behind the converter logic
`timescale 1ns/10ps
module acc_core_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Mux gates and trial code
	input wire logic [15:0] posSelect,
	input wire logic [15:0] negSelect,
	input wire logic [9:0] trialCode,
	input wire logic convPower,
	// Comparator
	output logic compHigh
);
	logic [9:0] vPos, vNeg, level;
	logic cmpReg;
	always_comb begin // Inputs seen only as fixed analog levels
		vPos = '0;
		vNeg = '0;
		for (int i = 0; i < 16; i++) begin
			if (posSelect[i]) vPos = 10'(60 * i + 7);
			if (negSelect[i]) vNeg = 10'(60 * i + 7);
		end
		level = (vPos > vNeg) ? vPos - vNeg : 10'h000;
	end
	// Unpowered output toggles so a stale level is never trusted
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) cmpReg <= 1'b0;
		else if (!convPower) cmpReg <= !cmpReg;
	end
	// Powered comparator judges the code now on the trial lines
	assign compHigh = arst_n & (convPower ? (level >= trialCode) : cmpReg);
endmodule // acc_core_model

// File: acc_checker_sva.sv
// Port checks for the converter channel control block
`timescale 1ns/10ps
module acc_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// Converter and mux
	input wire logic convPower,
	input wire logic convTick,
	input wire logic sampleOn,
	input wire logic autoZeroOn,
	input wire logic [15:0] posSelect,
	input wire logic [15:0] negSelect,
	input wire logic negToGround,
	input wire logic muxPinRoute
);
	import acc_pkg::*;
	logic wrCtl, seenTick;
	logic [4:0] tickCnt, gapCnt;
	logic [15:0] pairSel;
	assign wrCtl = psel && penable && pready && pwrite && paddr == ACC_OFF_CONTROL && pstrb[0];
	assign pairSel = ((posSelect & 16'h5555) << 1) | ((posSelect & 16'haaaa) >> 1);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) tickCnt <= '0;
		else if (!convPower) tickCnt <= '0;
		else if (convTick) tickCnt <= tickCnt + 5'h01;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gapCnt <= '0;
			seenTick <= 1'b0;
		end else begin
			gapCnt <= convTick ? 5'h00 : gapCnt + 5'h01;
			seenTick <= convPower && (seenTick || convTick);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_start_by_write: assert property ($rose(convPower) |->
		$past(wrCtl && pwdata[0]) || $past(wrCtl && pwdata[0], 2)) else $error("start without write");
	a_tick_bound: assert property (convPower |-> tickCnt <= 5'd15)
		else $error("too many ticks");
	a_full_count: assert property ($fell(convPower) && !$past(wrCtl) && !$past(wrCtl, 2)
		|-> $past(tickCnt) inside {5'd14, 5'd15}) else $error("short conversion");
	a_sample_phase: assert property (sampleOn |-> convPower && tickCnt <= 5'd3)
		else $error("sample phase length");
	a_azero_phase: assert property (autoZeroOn |-> tickCnt inside {5'd3, 5'd4})
		else $error("auto-zero misplaced");
	a_tick_spacing: assert property (convTick && seenTick |-> gapCnt inside {5'd0, 5'd15})
		else $error("tick spacing");
	a_idle_quiet: assert property (!convPower |-> !convTick && !sampleOn && !autoZeroOn)
		else $error("activity while off");
	a_single_ground: assert property (negToGround |-> negSelect == 16'h0000)
		else $error("negative gate in single mode");
	a_diff_pair: assert property (!negToGround && convPower && !muxPinRoute
		|-> negSelect == pairSel && $onehot(posSelect)) else $error("wrong pair");
	a_pos_single: assert property (negToGround && convPower && !muxPinRoute
		|-> $onehot(posSelect)) else $error("positive gate");
	a_fields_hold: assert property (convPower && $past(convPower) && $past(convPower, 2)
		|-> $stable(posSelect) && $stable(negToGround)) else $error("fields changed");
	a_route_cause: assert property ($rose(muxPinRoute) |->
		$past(wrCtl && pwdata[2]) || $past(wrCtl && pwdata[2], 2)) else $error("route cause");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	c_done: cover property ($fell(convPower));
	c_routed: cover property (muxPinRoute && !convPower);
	c_slow: cover property (convTick && seenTick && gapCnt == 5'd15);
endmodule // acc_checker
bind acc_adc_channel_control acc_checker acc_checker_i (.*);

// File: acc_adc_channel_control_tb.sv
// Testbench for the converter channel control block
`timescale 1ns/10ps
module acc_adc_channel_control_tb;
	import acc_pkg::*;
	logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, convPower, convTick, sampleOn, autoZeroOn;
	logic compHigh, negToGround, muxPinRoute;
	logic [9:0] trialCode;
	logic [15:0] posSelect, negSelect;
	int fails = 0, cmp_count = 0, k;
	acc_adc_channel_control acc_adc_channel_control_i (.*);
	acc_core_model acc_core_model_i (.*);
	initial forever #2.5 sys_clk = !sys_clk;
	function automatic logic [9:0] lvl(logic [3:0] c);
		return 10'(60 * c + 7);
	endfunction
	task automatic chk(logic [31:0] s, logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic t_conv(logic [3:0] ch, logic dif, logic dv);
		logic [9:0] e;
		e = lvl(ch);
		if (dif) e = (lvl(ch) > lvl(ch ^ 4'h1)) ? lvl(ch) - lvl(ch ^ 4'h1) : 10'h000;
		apb(1, ACC_OFF_CONTROL, {24'h0, ch, dif, 1'b0, dv, 1'b1});
		k = 0;
		do apb(0, ACC_OFF_STATUS, 0); while (rd[0] !== 1'b0 && ++k < 200);
		chk(32'(convPower), 0);
		apb(0, ACC_OFF_RESULT_HIGH, 0);
		chk(rd, 32'(e[9:2]));
		apb(0, ACC_OFF_RESULT_LOW, 0);
		chk(rd, {24'h0, e[1:0], 6'h00});
		repeat (40) @(posedge sys_clk);
		chk(32'(convPower), 0);
		$display("conversion test done");
	endtask
	task automatic t_time(logic dv, int lo, int hi);
		apb(1, ACC_OFF_CONTROL, {24'h0, 4'h8, 2'b00, dv, 1'b1});
		// Power follows the phase register one edge after the start
		repeat (2) @(posedge sys_clk);
		k = 2;
		while (convPower === 1'b1 && k < 300) begin
			@(posedge sys_clk);
			k++;
		end
		chk(32'(k >= lo && k <= hi), 1);
		$display("timing test done");
	endtask
	task automatic t_lock;
		apb(1, ACC_OFF_CONTROL, 32'h33);
		apb(1, ACC_OFF_CONTROL, 32'h9d);
		apb(0, ACC_OFF_CONTROL, 0);
		chk(rd, 32'h33);
		apb(1, ACC_OFF_CONTROL, 32'h32);
		apb(0, ACC_OFF_CONTROL, 0);
		chk(rd, 32'h32);
		pstrb <= 4'h0;
		apb(1, ACC_OFF_CONTROL, 32'h51);
		pstrb <= 4'hf;
		apb(0, ACC_OFF_CONTROL, 0);
		chk(rd, 32'h32);
		$display("lock test done");
	endtask
	task automatic t_mux;
		apb(1, ACC_OFF_CONTROL, 32'h54);
		apb(0, ACC_OFF_STATUS, 0);
		chk(rd, 32'h4);
		chk(32'(muxPinRoute), 1);
		chk(32'(posSelect), 32'h20);
		apb(1, ACC_OFF_CONTROL, 32'hcc);
		apb(0, ACC_OFF_STATUS, 0);
		chk(rd, 32'h6);
		apb(1, ACC_OFF_CONTROL, 32'he4);
		apb(0, ACC_OFF_STATUS, 0);
		chk(rd, 32'h6);
		apb(1, ACC_OFF_CONTROL, 32'he8);
		apb(0, ACC_OFF_STATUS, 0);
		chk(rd, 32'h0);
		apb(0, 12'h010, 0);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("mux test done");
	endtask
	task automatic t_reset;
		apb(1, ACC_OFF_CONTROL, 32'h33);
		repeat (5) @(posedge sys_clk);
		arst_n <= 0;
		repeat (3) @(posedge sys_clk);
		chk(32'(convPower), 0);
		arst_n <= 1;
		apb(0, ACC_OFF_CONTROL, 0);
		chk(rd, 32'h0);
		$display("reset test done");
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#100us;
		fails++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		arst_n <= 1;
		t_reset;
		t_conv(4'h0, 0, 0);
		t_conv(4'hf, 0, 0);
		t_conv(4'h7, 1, 0);
		t_conv(4'h2, 1, 0);
		t_conv(4'h9, 0, 1);
		t_time(0, 14, 18);
		t_time(1, 225, 260);
		t_lock;
		t_mux;
		complete_run;
	end
endmodule // acc_adc_channel_control_tb
